// File: hw/crs_top.sv
// reset sequencing, static configuration and level status pins of the core
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`include "crs_defines.svh"
`default_nettype none

module crs_top
(
    input wire logic clk, // core clock, 20 MHz
    input wire logic rst_b, // async power-on reset
    input wire logic hard_reset_in, // async cold reset, high active
    input wire logic endian_in, // static base endianness
    input wire logic [1:0] byte_enable_restrict_mode, // static byte enable mode
    input wire logic exc_valid, // exception taken this cycle
    input wire crs_pkg::crs_exc_type exc_kind, // kind of that exception
    input wire logic mem_req_valid, // load/store wants a bus pattern
    input wire logic [7:0] mem_req_mask, // load/store byte mask
    output logic [7:0] bus_be_out, // byte enables for the bus
    output logic bus_be_valid, // bus_be_out is valid
    output logic big_endian_out, // captured endianness
    output logic reset_exception_out, // one-cycle reset exception start
    output logic core_run_out, // core past reset
    output logic error_level_out, // mirrors error_level_bit
    output logic exception_level_out, // mirrors exception_level_bit
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [`CRS_ADR_W-1:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    output logic wb_err_o // wishbone error, unmapped address
);
    import crs_pkg::*;

    // =================================================================
    // hard reset synchroniser
    logic hr_meta;
    logic hr_sync;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hr_meta <= `CRS_SYNC_RST;
            hr_sync <= `CRS_SYNC_RST;
        end
        else
        begin
            hr_meta <= hard_reset_in;
            hr_sync <= hr_meta;
        end
    end

    a_sync_two_stage: assert property (@(posedge clk) disable iff (!rst_b)
        ##2 (hr_sync == $past(hard_reset_in, 2)))
        else $error("hard reset synchroniser delay wrong");

    // =================================================================
    // reset sequencer
    crs_state_type state;
    crs_state_type next_state;

    always_comb
    begin
        next_state = state;
        case (state)
            CRS_ST_HOLD: next_state = hr_sync ? CRS_ST_HOLD : CRS_ST_VECTOR;
            CRS_ST_VECTOR: next_state = hr_sync ? CRS_ST_HOLD : CRS_ST_RUN;
            CRS_ST_RUN: next_state = hr_sync ? CRS_ST_HOLD : CRS_ST_RUN;
            default: next_state = CRS_ST_HOLD;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= CRS_ST_HOLD;
        else
            state <= next_state;
    end

    assign reset_exception_out = (state == CRS_ST_VECTOR);
    assign core_run_out = (state == CRS_ST_RUN);

    a_reset_vector: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(hr_sync) |=> reset_exception_out ##1 (core_run_out || hr_sync))
        else $error("no reset exception after hard reset release");

    // =================================================================
    // static configuration, captured while hard reset is held
    logic cfg_big;
    logic next_cfg_big;
    crs_be_mode_type cfg_mode;
    crs_be_mode_type next_cfg_mode;

    always_comb
    begin
        next_cfg_big = cfg_big;
        next_cfg_mode = cfg_mode;
        if (hr_sync)
        begin
            next_cfg_big = endian_in;
            next_cfg_mode = crs_be_mode_type'(byte_enable_restrict_mode);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_big <= `CRS_LEVEL_RST;
            cfg_mode <= CRS_BE_LDST;
        end
        else
        begin
            cfg_big <= next_cfg_big;
            cfg_mode <= next_cfg_mode;
        end
    end

    assign big_endian_out = cfg_big;

    // =================================================================
    // byte enable generation
    crs_be_if be_bus ();

    assign be_bus.req_mask = mem_req_mask;
    assign be_bus.big_endian = cfg_big;
    assign be_bus.mode = cfg_mode;

    crs_be_gen u_be_gen (.bus(be_bus.gen));

    logic [7:0] next_bus_be;
    logic next_bus_be_valid;

    always_comb
    begin
        next_bus_be = bus_be_out;
        next_bus_be_valid = 1'b0;
        if (hr_sync)
            next_bus_be = `CRS_BE_RST;
        else if (mem_req_valid && core_run_out)
        begin
            next_bus_be = be_bus.be;
            next_bus_be_valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_be_out <= `CRS_BE_RST;
            bus_be_valid <= 1'b0;
        end
        else
        begin
            bus_be_out <= next_bus_be;
            bus_be_valid <= next_bus_be_valid;
        end
    end

    a_ldst_little: assert property (@(posedge clk) disable iff (!rst_b)
        bus_be_valid && cfg_mode == CRS_BE_LDST && !cfg_big |->
            bus_be_out == $past(mem_req_mask))
        else $error("mode 0 little-endian pattern altered");

    a_ldst_big: assert property (@(posedge clk) disable iff (!rst_b)
        bus_be_valid && cfg_mode == CRS_BE_LDST && cfg_big |->
            bus_be_out == crs_rev8($past(mem_req_mask)))
        else $error("big-endian lane order wrong");

    a_aligned_only: assert property (@(posedge clk) disable iff (!rst_b)
        bus_be_valid && cfg_mode != CRS_BE_LDST && $past(mem_req_mask) != 8'h00 |->
            crs_aligned(bus_be_out))
        else $error("unaligned pattern in restricted mode");

    // =================================================================
    // wishbone slave: ack one cycle after request, write on ack edge
    logic ack_q;
    logic next_ack;
    logic err_q;
    logic next_err;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic hit_status;
    logic hit_config;
    logic req_new;
    logic wr_status;

    assign hit_status = (wb_adr_i == `CRS_OFS_STATUS);
    assign hit_config = (wb_adr_i == `CRS_OFS_CONFIG);
    assign req_new = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign wr_status = ack_q && wb_cyc_i && wb_stb_i && wb_we_i && hit_status && wb_sel_i[0];

    always_comb
    begin
        next_ack = req_new && (hit_status || hit_config);
        next_err = req_new && !(hit_status || hit_config);
        next_rdata = `CRS_WORD_RST;
        if (req_new && !wb_we_i && hit_status)
        begin
            next_rdata[`CRS_STAT_ERL] = error_level_out;
            next_rdata[`CRS_STAT_EXL] = exception_level_out;
            next_rdata[`CRS_STAT_RUN] = core_run_out;
        end
        else if (req_new && !wb_we_i && hit_config)
        begin
            next_rdata[`CRS_CFG_ENDIAN] = cfg_big;
            next_rdata[`CRS_CFG_MODE_HI:`CRS_CFG_MODE_LO] = cfg_mode;
            next_rdata[`CRS_CFG_RSVD] = cfg_mode inside {CRS_BE_RSVD2, CRS_BE_RSVD3};
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdata <= `CRS_WORD_RST;
        end
        else
        begin
            ack_q <= next_ack;
            err_q <= next_err;
            rdata <= next_rdata;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdata;

    // =================================================================
    // error and exception level bits; set wins over software clear
    logic erl_set;
    logic exl_set;
    logic next_erl;
    logic next_exl;

    assign erl_set = exc_valid && core_run_out && !(exc_kind inside {CRS_EXC_RESET,
        CRS_EXC_SOFT_RESET, CRS_EXC_NMI, CRS_EXC_CACHE_ERR});
    assign exl_set = exc_valid && core_run_out && !(exc_kind inside {CRS_EXC_RESET,
        CRS_EXC_SOFT_RESET, CRS_EXC_NMI, CRS_EXC_CACHE_ERR, CRS_EXC_DEBUG});

    always_comb
    begin
        next_erl = error_level_out;
        next_exl = exception_level_out;
        if (wr_status && wb_dat_i[`CRS_STAT_ERL])
            next_erl = 1'b0;
        if (wr_status && wb_dat_i[`CRS_STAT_EXL])
            next_exl = 1'b0;
        if (erl_set)
            next_erl = 1'b1;
        if (exl_set)
            next_exl = 1'b1;
        if (hr_sync)
        begin
            next_erl = `CRS_LEVEL_RST;
            next_exl = `CRS_LEVEL_RST;
        end
    end

    // the pins are the status flops themselves
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            error_level_out <= `CRS_LEVEL_RST;
            exception_level_out <= `CRS_LEVEL_RST;
        end
        else
        begin
            error_level_out <= next_erl;
            exception_level_out <= next_exl;
        end
    end

    a_hold_clears: assert property (@(posedge clk) disable iff (!rst_b)
        hr_sync |=> !error_level_out && !exception_level_out && !bus_be_valid)
        else $error("state kept while hard reset held");

    a_erl_set: assert property (@(posedge clk) disable iff (!rst_b)
        exc_valid && core_run_out && !hr_sync && exc_kind == CRS_EXC_DEBUG |=>
            error_level_out && !$changed(exception_level_out))
        else $error("debug exception handled wrong on level bits");

    a_exl_set: assert property (@(posedge clk) disable iff (!rst_b)
        exc_valid && core_run_out && !hr_sync && exc_kind == CRS_EXC_OTHER |=>
            exception_level_out && error_level_out)
        else $error("ordinary exception did not raise levels");

    a_w1c_clear: assert property (@(posedge clk) disable iff (!rst_b)
        wr_status && wb_dat_i[`CRS_STAT_ERL] && !erl_set |=> !error_level_out)
        else $error("error level not cleared by software");

    a_nmi_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        exc_valid && exc_kind == CRS_EXC_NMI && !wr_status && !hr_sync |=>
            $stable(exception_level_out) && $stable(error_level_out))
        else $error("nmi changed level bits");

endmodule : crs_top

`default_nettype wire

// File: hw/crs_defines.svh
// register offsets, field positions and reset values of the reset/config/status block
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

// =====================================================================
// register map (byte addresses, one 32-bit word each)
`define CRS_OFS_STATUS 8'h00
`define CRS_OFS_CONFIG 8'h04
`define CRS_ADR_W 8

// =====================================================================
// status register fields
`define CRS_STAT_ERL 0
`define CRS_STAT_EXL 1
`define CRS_STAT_RUN 2

// =====================================================================
// config register fields
`define CRS_CFG_ENDIAN 0
`define CRS_CFG_MODE_LO 1
`define CRS_CFG_MODE_HI 2
`define CRS_CFG_RSVD 3

// =====================================================================
// reset values
`define CRS_LEVEL_RST 1'b0
`define CRS_SYNC_RST 1'b1
`define CRS_BE_RST 8'h00
`define CRS_WORD_RST 32'h0000_0000

`endif

// File: hw/crs_pkg.sv
// types and shared decode functions of the reset/config/status block
`default_nettype none

package crs_pkg;

    // =================================================================
    // types
    typedef enum logic [1:0] {
        CRS_BE_LDST,
        CRS_BE_ALIGNED,
        CRS_BE_RSVD2,
        CRS_BE_RSVD3
    } crs_be_mode_type;

    typedef enum logic [2:0] {
        CRS_EXC_RESET,
        CRS_EXC_SOFT_RESET,
        CRS_EXC_NMI,
        CRS_EXC_CACHE_ERR,
        CRS_EXC_DEBUG,
        CRS_EXC_OTHER
    } crs_exc_type;

    typedef enum logic [1:0] {
        CRS_ST_HOLD,
        CRS_ST_VECTOR,
        CRS_ST_RUN
    } crs_state_type;

    // =================================================================
    // functions
    // byte lane reversal for big-endian lane order
    function automatic logic [7:0] crs_rev8(input logic [7:0] m);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = m[7 - i];
        end
        return r;
    endfunction : crs_rev8

    // naturally aligned byte, half, word or dword pattern
    function automatic logic crs_aligned(input logic [7:0] m);
        return m inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                         8'h03, 8'h0c, 8'h30, 8'hc0, 8'h0f, 8'hf0, 8'hff};
    endfunction : crs_aligned

endpackage : crs_pkg

`default_nettype wire

// File: hw/crs_be_if.sv
// carrier between the core logic and the byte enable generator
`default_nettype none

interface crs_be_if;
    import crs_pkg::*;

    logic [7:0] req_mask;
    logic big_endian;
    crs_be_mode_type mode;
    logic [7:0] be;

    modport core (output req_mask, output big_endian, output mode, input be);
    modport gen (input req_mask, input big_endian, input mode, output be);
endinterface : crs_be_if

`default_nettype wire

// File: hw/crs_be_gen.sv
// byte enable pattern generator: endian lane order and restriction mode
`default_nettype none

module crs_be_gen
(
    crs_be_if.gen bus // mask in, pattern out
);
    import crs_pkg::*;

    // smallest naturally aligned unit covering the mask
    function automatic logic [7:0] crs_cover(input logic [7:0] m);
        logic [7:0] r;
        r = 8'hff;
        for (int i = 0; i < 2; i++)
        begin
            if ((m & ~(8'h0f << (4 * i))) == 8'h00)
                r = 8'h0f << (4 * i);
        end
        for (int i = 0; i < 4; i++)
        begin
            if ((m & ~(8'h03 << (2 * i))) == 8'h00)
                r = 8'h03 << (2 * i);
        end
        for (int i = 0; i < 8; i++)
        begin
            if ((m & ~(8'h01 << i)) == 8'h00)
                r = 8'h01 << i;
        end
        if (m == 8'h00)
            r = 8'h00;
        return r;
    endfunction : crs_cover

    logic [7:0] lanes;

    always_comb
    begin
        lanes = bus.big_endian ? crs_rev8(bus.req_mask) : bus.req_mask;
        case (bus.mode)
            CRS_BE_LDST: bus.be = lanes;
            CRS_BE_ALIGNED: bus.be = crs_cover(lanes);
            default: bus.be = crs_cover(lanes);
        endcase
    end

endmodule : crs_be_gen

`default_nettype wire

// File: sim/crs_sys_model.sv
// system side model: drives hard reset and the static straps
`default_nettype none

module crs_sys_model
#(
    parameter int HOLD_CYCLES = 12
)
(
    input wire logic clk, // core clock
    input wire logic rst_b, // power-on reset
    input wire logic cold_req, // bench asks for a cold reset
    input wire logic want_big, // wanted endianness
    input wire logic [1:0] want_mode, // wanted byte enable mode
    output logic hard_reset_in, // cold reset to the core
    output logic endian_in, // endian strap
    output logic [1:0] byte_enable_restrict_mode // mode strap
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt;

    // =================================================================
    // hard reset and strap sequencing
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hard_reset_in <= 1'b1;
            cnt <= HOLD_CYCLES;
            endian_in <= 1'b0;
            byte_enable_restrict_mode <= 2'h0;
        end
        else if (cold_req)
        begin
            hard_reset_in <= 1'b1;
            cnt <= HOLD_CYCLES;
        end
        else if (cnt != 0)
        begin
            cnt <= cnt - 1;
            endian_in <= want_big;
            byte_enable_restrict_mode <= {1'b0, want_mode[0]};
        end
        else
        begin
            hard_reset_in <= 1'b0;
        end
    end
endmodule : crs_sys_model

`default_nettype wire

// File: sim/tb_crs_top.sv
// bench for the reset, configuration and level status pins
`default_nettype none

module tb_crs_top;
    timeunit 1ns;
    timeprecision 100ps;
    import crs_pkg::*;

    logic clk, rst_b, cold_req, want_big, hard_reset_in, endian_in;
    logic [1:0] want_mode, mode;
    logic exc_valid, mem_req_valid, bus_be_valid, big_endian_out;
    crs_exc_type exc_kind;
    logic [7:0] mem_req_mask, bus_be_out, wb_adr_i;
    logic reset_exception_out, core_run_out, error_level_out, exception_level_out;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic er;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] masks [8] = '{8'h01, 8'h06, 8'h18, 8'h0e, 8'h3c, 8'hf0, 8'h81, 8'h00};

    crs_sys_model sys (.clk(clk), .rst_b(rst_b), .cold_req(cold_req), .want_big(want_big),
        .want_mode(want_mode), .hard_reset_in(hard_reset_in), .endian_in(endian_in),
        .byte_enable_restrict_mode(mode));

    crs_top dut (.clk(clk), .rst_b(rst_b), .hard_reset_in(hard_reset_in),
        .endian_in(endian_in), .byte_enable_restrict_mode(mode), .exc_valid(exc_valid),
        .exc_kind(exc_kind), .mem_req_valid(mem_req_valid), .mem_req_mask(mem_req_mask),
        .bus_be_out(bus_be_out), .bus_be_valid(bus_be_valid), .big_endian_out(big_endian_out),
        .reset_exception_out(reset_exception_out), .core_run_out(core_run_out),
        .error_level_out(error_level_out), .exception_level_out(exception_level_out),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o));

    // =================================================================
    // clock and timeout
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    // =================================================================
    // helpers
    task automatic report_and_stop();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hf;
        do
        begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    // smallest aligned cover, then lane reversal
    function automatic logic [7:0] exp_be(input logic [7:0] m, input logic md, input logic bg);
        logic [7:0] r, u, o;
        r = m;
        for (int s = 8; s >= 1; s = s / 2)
            for (int b = 0; b < 8; b += s)
            begin
                u = 8'((8'hff >> (8 - s)) << b);
                if (md && m != 8'h00 && (m & ~u) == 8'h00)
                    r = u;
            end
        for (int i = 0; i < 8; i++)
            o[i] = r[7 - i];
        return bg ? o : r;
    endfunction : exp_be

    task automatic pulse_exc(input crs_exc_type k);
        @(posedge clk);
        exc_valid <= 1'b1;
        exc_kind <= k;
        @(posedge clk);
        exc_valid <= 1'b0;
        @(negedge clk);
    endtask : pulse_exc

    task automatic wait_boot();
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (reset_exception_out !== 1'b1 && n < 64);
        chk_bit(reset_exception_out, 1'b1);
        chk_bit(core_run_out, 1'b0);
        @(negedge clk);
        chk_bit(reset_exception_out, 1'b0);
        chk_bit(core_run_out, 1'b1);
    endtask : wait_boot

    // =================================================================
    // scenarios
    task automatic t_be_and_cfg(input logic bg, input logic md);
        chk_bit(big_endian_out, bg);
        wb_xfer(1'b0, 8'h04, 32'h0);
        chk_word(rd, {29'h0, 1'b0, md, bg});
        foreach (masks[i])
        begin
            @(posedge clk);
            mem_req_valid <= 1'b1;
            mem_req_mask <= masks[i];
            @(posedge clk);
            mem_req_valid <= 1'b0;
            @(negedge clk);
            chk_bit(bus_be_valid, 1'b1);
            chk_word({24'h0, bus_be_out}, {24'h0, exp_be(masks[i], md, bg)});
            @(negedge clk);
            chk_bit(bus_be_valid, 1'b0);
        end
        $display("test byte enables big=%0d mode=%0d done", bg, md);
    endtask : t_be_and_cfg

    task automatic t_levels();
        logic e, x;
        for (int k = 0; k < 6; k++)
        begin
            e = (k == 4 || k == 5);
            x = (k == 5);
            pulse_exc(crs_exc_type'(k));
            chk_bit(error_level_out, e);
            chk_bit(exception_level_out, x);
            wb_xfer(1'b0, 8'h00, 32'h0);
            chk_word(rd, {29'h0, 1'b1, x, e});
            wb_xfer(1'b1, 8'h00, 32'h7);
            @(negedge clk);
            chk_bit(error_level_out, 1'b0);
            chk_bit(exception_level_out, 1'b0);
        end
        $display("test level outputs done");
    endtask : t_levels

    task automatic t_regs();
        wb_xfer(1'b1, 8'h04, 32'hf);
        chk_bit(er, 1'b0);
        wb_xfer(1'b0, 8'h04, 32'h0);
        chk_word(rd, 32'h0);
        wb_xfer(1'b0, 8'h08, 32'h0);
        chk_bit(er, 1'b1);
        wb_xfer(1'b0, 8'h00, 32'h0);
        chk_word(rd, 32'h4);
        $display("test register bus done");
    endtask : t_regs

    task automatic t_cold(input logic bg, input logic [1:0] md);
        pulse_exc(CRS_EXC_OTHER);
        @(posedge clk);
        want_big <= bg;
        want_mode <= md;
        cold_req <= 1'b1;
        @(posedge clk);
        cold_req <= 1'b0;
        repeat (4) @(negedge clk);
        chk_bit(error_level_out, 1'b0);
        chk_bit(exception_level_out, 1'b0);
        chk_bit(core_run_out, 1'b0);
        pulse_exc(CRS_EXC_OTHER);
        chk_bit(error_level_out, 1'b0);
        wait_boot();
        t_be_and_cfg(bg, md[0]);
        $display("test cold reset done");
    endtask : t_cold

    // =================================================================
    // main sequence
    initial
    begin
        rst_b = 1'b0;
        cold_req = 1'b0;
        want_big = 1'b0;
        want_mode = 2'h0;
        exc_valid = 1'b0;
        exc_kind = CRS_EXC_RESET;
        mem_req_valid = 1'b0;
        mem_req_mask = 8'h00;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        wait_boot();
        t_regs();
        t_levels();
        t_be_and_cfg(1'b0, 1'b0);
        t_cold(1'b1, 2'h1);
        t_cold(1'b0, 2'h1);
        t_cold(1'b1, 2'h0);
        t_cold(1'b0, 2'h2);
        report_and_stop();
    end
endmodule : tb_crs_top

`default_nettype wire
